//--- logic/rsi_pkg.sv
// constants for the receive status and target interrupt register group
package rsi_pkg;
  // printed register indices; byte address is four times the index
  localparam logic [7:0] RSI_IDX_PT_IRQ    = 8'h1D;
  localparam logic [7:0] RSI_IDX_FIFO_LO   = 8'h1E;
  localparam logic [7:0] RSI_IDX_FIFO_HI   = 8'h1F;
  localparam logic [7:0] RSI_IDX_COLL      = 8'h20;
  // block interrupt registers, byte addresses
  localparam logic [7:0] RSI_ADDR_BLK_STAT = 8'hC0;
  localparam logic [7:0] RSI_ADDR_BLK_MASK = 8'hC4;
  // passive target interrupt bit positions
  localparam int RSI_PT_FIELD_WAIT = 7;
  localparam int RSI_PT_SLOT_LOW   = 6;
  localparam int RSI_PT_P2P_ON     = 5;
  localparam int RSI_PT_AUTO_REPLY = 4;
  localparam int RSI_PT_NFCF       = 3;
  localparam int RSI_PT_RSVD       = 2;
  localparam int RSI_PT_STAR       = 1;
  localparam int RSI_PT_ACTIVE     = 0;
  // block status bit positions
  localparam int RSI_BS_PT    = 0;
  localparam int RSI_BS_UNF   = 1;
  localparam int RSI_BS_OVR   = 2;
  localparam int RSI_BS_COLL  = 3;
  localparam int RSI_BS_HARD  = 4;
  localparam int RSI_BS_WIDTH = 5;
  // fifo geometry
  localparam int              RSI_CNT_W    = 10;
  localparam logic [9:0]      RSI_FIFO_MAX = 10'h200;
  localparam logic [9:0]      RSI_CNT_ONE  = 10'h001;
  // reset values
  localparam logic [7:0]      RSI_RST_BYTE = 8'h00;
  localparam logic [4:0]      RSI_RST_MASK = 5'h00;
  // axi responses
  localparam logic [1:0]      RSI_RESP_OK  = 2'h0;
  localparam logic [1:0]      RSI_RESP_ERR = 2'h2;
endpackage

//--- logic/rsi_regs.sv
// receive status and passive target interrupt registers behind AXI4-Lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module rsi_regs
  import rsi_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // axi4-lite write address and data
  input  wire logic       i_awvalid,
  output logic            o_awready,
  input  wire logic [7:0] i_awaddr,
  input  wire logic       i_wvalid,
  output logic            o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic            o_bvalid,
  input  wire logic       i_bready,
  output logic [1:0]      o_bresp,
  // axi4-lite read
  input  wire logic       i_arvalid,
  output logic            o_arready,
  input  wire logic [7:0] i_araddr,
  output logic            o_rvalid,
  input  wire logic       i_rready,
  output logic [31:0]     o_rdata,
  output logic [1:0]      o_rresp,
  // target events, one-cycle pulses
  input  wire logic       i_field_wait_timer_irq,
  input  wire logic       i_slot_supply_low_irq,
  input  wire logic       i_p2p_field_on_irq,
  input  wire logic       i_auto_reply_sent_irq,
  input  wire logic       i_nfcf_target_active_irq,
  input  wire logic       i_nfca_target_active_star_irq,
  input  wire logic       i_nfca_target_active_irq,
  // fifo traffic
  input  wire logic       i_fifo_push,
  input  wire logic       i_fifo_pop,
  input  wire logic       i_fifo_clear,
  // receive frame end
  input  wire logic       i_rx_frame_end,
  input  wire logic [2:0] i_rx_last_bits,
  input  wire logic [7:0] i_rx_shift,
  input  wire logic       i_rx_missing_parity,
  input  wire logic       i_hard_framing_error_irq,
  // collision report
  input  wire logic       i_coll_event,
  input  wire logic       i_coll_in_anticoll,
  input  wire logic [3:0] i_coll_bytes,
  input  wire logic [2:0] i_coll_bits,
  input  wire logic       i_collision_in_parity,
  // outputs to the receive path and system
  output logic [7:0]      o_rx_last_byte,
  output logic            o_rx_last_byte_valid,
  output logic            o_irq
);

  // bus state
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_lane0_r, w_lane0_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_fire, rd_fire;

  // status state
  logic [7:0]  pt_irq_r, pt_irq_nxt, pt_set;
  logic [9:0]  fifo_cnt_r, fifo_cnt_nxt;
  logic        unf_r, unf_nxt, ovr_r, ovr_nxt, unf_ev, ovr_ev;
  logic [2:0]  lb_bits_r, lb_bits_nxt;
  logic        nopar_r, nopar_nxt;
  logic [7:0]  coll_r, coll_nxt;
  logic        coll_upd;
  logic [4:0]  blk_stat_r, blk_stat_nxt, blk_mask_r, blk_mask_nxt, blk_set;
  logic        irq_r, irq_nxt;
  logic [7:0]  last_byte_r, last_byte_nxt;
  logic        last_vld_r, last_vld_nxt;

  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  assign rd_fire = i_arvalid & arready_r;

  // event vector in register order; bit 2 never sets
  always_comb begin
    pt_set                    = RSI_RST_BYTE;
    pt_set[RSI_PT_FIELD_WAIT] = i_field_wait_timer_irq;
    pt_set[RSI_PT_SLOT_LOW]   = i_slot_supply_low_irq;
    pt_set[RSI_PT_P2P_ON]     = i_p2p_field_on_irq;
    pt_set[RSI_PT_AUTO_REPLY] = i_auto_reply_sent_irq;
    pt_set[RSI_PT_NFCF]       = i_nfcf_target_active_irq;
    pt_set[RSI_PT_STAR]       = i_nfca_target_active_star_irq;
    pt_set[RSI_PT_ACTIVE]     = i_nfca_target_active_irq;
  end

  // bus slave
  always_comb begin
    aw_got_nxt  = aw_got_r;
    aw_addr_nxt = aw_addr_r;
    w_got_nxt   = w_got_r;
    w_data_nxt  = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (i_awvalid && awready_r) begin
      aw_got_nxt  = 1'b1;
      aw_addr_nxt = i_awaddr;
    end
    if (i_wvalid && wready_r) begin
      w_got_nxt   = 1'b1;
      w_data_nxt  = i_wdata;
      w_lane0_nxt = i_wstrb[0];
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      // read-only status words accept writes silently
      unique case (aw_addr_r)
        RSI_ADDR_BLK_STAT, RSI_ADDR_BLK_MASK,
        {RSI_IDX_PT_IRQ[5:0], 2'b00}, {RSI_IDX_FIFO_LO[5:0], 2'b00},
        {RSI_IDX_FIFO_HI[5:0], 2'b00}, {RSI_IDX_COLL[5:0], 2'b00}:
          bresp_nxt = RSI_RESP_OK;
        default:
          bresp_nxt = RSI_RESP_ERR;
      endcase
    end
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RSI_RESP_OK;
      rdata_nxt  = 32'h0000_0000;
      unique case (i_araddr)
        {RSI_IDX_PT_IRQ[5:0], 2'b00}:  rdata_nxt[7:0] = pt_irq_r;
        {RSI_IDX_FIFO_LO[5:0], 2'b00}: rdata_nxt[7:0] = fifo_cnt_r[7:0];
        {RSI_IDX_FIFO_HI[5:0], 2'b00}:
          rdata_nxt[7:0] = {fifo_cnt_r[9:8], unf_r, ovr_r, lb_bits_r, nopar_r};
        {RSI_IDX_COLL[5:0], 2'b00}:    rdata_nxt[7:0] = coll_r;
        RSI_ADDR_BLK_STAT:             rdata_nxt[4:0] = blk_stat_r;
        RSI_ADDR_BLK_MASK:             rdata_nxt[4:0] = blk_mask_r;
        default:                       rresp_nxt      = RSI_RESP_ERR;
      endcase
    end
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      aw_addr_r <= RSI_RST_BYTE;
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RSI_RESP_OK;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RSI_RESP_OK;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_got_r  <= aw_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_got_r   <= w_got_nxt;
      w_data_r  <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // status logic
  always_comb begin
    // read clears, but an event in the same cycle still lands
    pt_irq_nxt = pt_irq_r | pt_set;
    if (rd_fire && i_araddr == {RSI_IDX_PT_IRQ[5:0], 2'b00}) begin
      pt_irq_nxt = pt_set;
    end
    // push on full or pop on empty leaves the count alone
    unf_ev       = i_fifo_pop & ~i_fifo_push & (fifo_cnt_r == 10'h000);
    ovr_ev       = i_fifo_push & ~i_fifo_pop & (fifo_cnt_r == RSI_FIFO_MAX);
    fifo_cnt_nxt = fifo_cnt_r;
    unf_nxt      = unf_r | unf_ev;
    ovr_nxt      = ovr_r | ovr_ev;
    if (i_fifo_push && !i_fifo_pop && !ovr_ev) begin
      fifo_cnt_nxt = fifo_cnt_r + RSI_CNT_ONE;
    end else if (i_fifo_pop && !i_fifo_push && !unf_ev) begin
      fifo_cnt_nxt = fifo_cnt_r - RSI_CNT_ONE;
    end
    if (i_fifo_clear) begin
      fifo_cnt_nxt = 10'h000;
      unf_nxt      = 1'b0;
      ovr_nxt      = 1'b0;
    end
    // last-byte report, left justified shift register aligned to bit 0
    lb_bits_nxt   = lb_bits_r;
    nopar_nxt     = nopar_r;
    last_byte_nxt = last_byte_r;
    last_vld_nxt  = i_rx_frame_end;
    if (i_rx_frame_end) begin
      lb_bits_nxt   = i_rx_last_bits;
      nopar_nxt     = i_rx_missing_parity & (i_rx_last_bits == 3'h0);
      last_byte_nxt = i_rx_shift >> (4'h8 - {1'b0, i_rx_last_bits});
      if (i_rx_last_bits == 3'h0) begin
        last_byte_nxt = i_rx_shift;
      end
    end
    // collisions outside the anticollision span are not recorded
    coll_upd = i_coll_event & i_coll_in_anticoll;
    coll_nxt = coll_r;
    if (coll_upd) begin
      coll_nxt = {i_coll_bytes, i_coll_bits, i_collision_in_parity};
    end
    // block interrupt: sticky, write one to clear, set wins
    blk_set              = 5'h00;
    blk_set[RSI_BS_PT]   = |pt_set;
    blk_set[RSI_BS_UNF]  = unf_ev;
    blk_set[RSI_BS_OVR]  = ovr_ev;
    blk_set[RSI_BS_COLL] = coll_upd;
    blk_set[RSI_BS_HARD] = i_hard_framing_error_irq;
    blk_stat_nxt = blk_stat_r;
    blk_mask_nxt = blk_mask_r;
    if (wr_fire && w_lane0_r && aw_addr_r == RSI_ADDR_BLK_STAT) begin
      blk_stat_nxt = blk_stat_r & ~w_data_r[4:0];
    end
    if (wr_fire && w_lane0_r && aw_addr_r == RSI_ADDR_BLK_MASK) begin
      blk_mask_nxt = w_data_r[4:0];
    end
    blk_stat_nxt = blk_stat_nxt | blk_set;
    irq_nxt      = |(blk_stat_nxt & blk_mask_nxt);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pt_irq_r    <= RSI_RST_BYTE;
      fifo_cnt_r  <= 10'h000;
      unf_r       <= 1'b0;
      ovr_r       <= 1'b0;
      lb_bits_r   <= 3'h0;
      nopar_r     <= 1'b0;
      coll_r      <= RSI_RST_BYTE;
      blk_stat_r  <= RSI_RST_MASK;
      blk_mask_r  <= RSI_RST_MASK;
      irq_r       <= 1'b0;
      last_byte_r <= RSI_RST_BYTE;
      last_vld_r  <= 1'b0;
    end else begin
      pt_irq_r    <= pt_irq_nxt;
      fifo_cnt_r  <= fifo_cnt_nxt;
      unf_r       <= unf_nxt;
      ovr_r       <= ovr_nxt;
      lb_bits_r   <= lb_bits_nxt;
      nopar_r     <= nopar_nxt;
      coll_r      <= coll_nxt;
      blk_stat_r  <= blk_stat_nxt;
      blk_mask_r  <= blk_mask_nxt;
      irq_r       <= irq_nxt;
      last_byte_r <= last_byte_nxt;
      last_vld_r  <= last_vld_nxt;
    end
  end

  assign o_awready            = awready_r;
  assign o_wready             = wready_r;
  assign o_bvalid             = bvalid_r;
  assign o_bresp              = bresp_r;
  assign o_arready            = arready_r;
  assign o_rvalid             = rvalid_r;
  assign o_rdata              = rdata_r;
  assign o_rresp              = rresp_r;
  assign o_rx_last_byte       = last_byte_r;
  assign o_rx_last_byte_valid = last_vld_r;
  assign o_irq                = irq_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_pt_read_clear;
    rd_fire && i_araddr == {RSI_IDX_PT_IRQ[5:0], 2'b00} && pt_set == 8'h00
      |=> pt_irq_r == 8'h00 && rdata_r[7:0] == $past(pt_irq_r);
  endproperty
  a_pt_read_clear: assert property (p_pt_read_clear)
    else $error("target irq register not cleared by read");
  property p_field_wait;
    i_field_wait_timer_irq |=> pt_irq_r[RSI_PT_FIELD_WAIT];
  endproperty
  a_field_wait: assert property (p_field_wait)
    else $error("field wait timer event lost");
  property p_slot_low;
    i_slot_supply_low_irq |=> pt_irq_r[RSI_PT_SLOT_LOW];
  endproperty
  a_slot_low: assert property (p_slot_low)
    else $error("slot supply event lost");
  property p_p2p_on;
    i_p2p_field_on_irq |=> pt_irq_r[RSI_PT_P2P_ON];
  endproperty
  a_p2p_on: assert property (p_p2p_on)
    else $error("peer field on event lost");
  property p_auto_reply;
    i_auto_reply_sent_irq |=> pt_irq_r[RSI_PT_AUTO_REPLY] && blk_stat_r[RSI_BS_PT];
  endproperty
  a_auto_reply: assert property (p_auto_reply)
    else $error("auto reply event lost");
  property p_nfcf;
    i_nfcf_target_active_irq |=> pt_irq_r[RSI_PT_NFCF];
  endproperty
  a_nfcf: assert property (p_nfcf)
    else $error("nfcf target event lost");
  property p_star_rsvd;
    (i_nfca_target_active_star_irq |=> pt_irq_r[RSI_PT_STAR]) and !pt_irq_r[RSI_PT_RSVD];
  endproperty
  a_star_rsvd: assert property (p_star_rsvd)
    else $error("star active bit wrong or reserved bit set");
  property p_active;
    i_nfca_target_active_irq |=> pt_irq_r[RSI_PT_ACTIVE];
  endproperty
  a_active: assert property (p_active)
    else $error("active event lost");
  property p_cnt_range;
    fifo_cnt_r <= RSI_FIFO_MAX;
  endproperty
  a_cnt_range: assert property (p_cnt_range)
    else $error("fifo count above limit");
  property p_cnt_push;
    i_fifo_push && !i_fifo_pop && !i_fifo_clear && fifo_cnt_r < RSI_FIFO_MAX
      |=> fifo_cnt_r == $past(fifo_cnt_r) + RSI_CNT_ONE;
  endproperty
  a_cnt_push: assert property (p_cnt_push)
    else $error("fifo count missed a push");
  property p_ovr;
    i_fifo_push && !i_fifo_pop && !i_fifo_clear && fifo_cnt_r == RSI_FIFO_MAX
      |=> ovr_r && fifo_cnt_r == RSI_FIFO_MAX;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overflow not flagged");
  property p_last_bits;
    i_rx_frame_end |=> lb_bits_r == $past(i_rx_last_bits)
      && (nopar_r == ($past(i_rx_missing_parity) && $past(i_rx_last_bits) == 3'h0));
  endproperty
  a_last_bits: assert property (p_last_bits)
    else $error("last byte report wrong");
  property p_coll_load;
    coll_upd |=> coll_r == $past({i_coll_bytes, i_coll_bits, i_collision_in_parity});
  endproperty
  a_coll_load: assert property (p_coll_load)
    else $error("collision register not loaded");
  property p_coll_hold;
    !coll_upd |=> $stable(coll_r);
  endproperty
  a_coll_hold: assert property (p_coll_hold)
    else $error("collision register changed outside anticollision");
  property p_irq;
    o_irq == |(blk_stat_r & blk_mask_r);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

endmodule

//--- test/rsi_host_model.sv
// AXI4-Lite host model that reaches the status registers
`timescale 1ns/1ps
module rsi_host_model (
  // clock
  input  wire logic        i_clk,
  // write address, data and response
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [7:0]       o_awaddr,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  input  wire logic [1:0]  i_bresp,
  // read address and data
  output logic             o_arvalid,
  input  wire logic        i_arready,
  output logic [7:0]       o_araddr,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  // cycles before rready rises, for slow reads
  int lag = 0;
  initial begin
    o_awvalid = 1'b0;
    o_awaddr  = 8'h00;
    o_wvalid  = 1'b0;
    o_wdata   = 32'h0;
    o_wstrb   = 4'h1;
    o_bready  = 1'b0;
    o_arvalid = 1'b0;
    o_araddr  = 8'h00;
    o_rready  = 1'b0;
  end
  // sample at the falling edge: registered outputs there equal what the rising edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_wdata   <= d;
    o_bready  <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = o_awvalid & i_awready;
      tw = o_wvalid & i_wready;
      tb = i_bvalid & o_bready;
      r  = i_bresp;
      @(posedge i_clk);
      // released lines show the inverse, never the stale value
      if (ta) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (tw) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
      if (tb) o_bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ta, tr;
    k = 0;
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= (lag == 0);
    do begin
      @(negedge i_clk);
      ta = o_arvalid & i_arready;
      tr = i_rvalid & o_rready;
      d  = i_rdata;
      r  = i_rresp;
      @(posedge i_clk);
      k++;
      if (ta) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
      if (k >= lag) o_rready <= !tr;
    end while (!tr);
  endtask
endmodule

//--- test/test_rsi_regs.sv
// self-checking bench for the receive status and target interrupt registers
`timescale 1ns/1ps
module test_rsi_regs
  import rsi_pkg::*;
;
  localparam logic [7:0] A_PT = RSI_IDX_PT_IRQ << 2;
  localparam logic [7:0] A_LO = RSI_IDX_FIFO_LO << 2;
  localparam logic [7:0] A_HI = RSI_IDX_FIFO_HI << 2;
  localparam logic [7:0] A_CO = RSI_IDX_COLL << 2;
  localparam logic [7:0] A_ST = RSI_ADDR_BLK_STAT;
  localparam logic [7:0] A_MK = RSI_ADDR_BLK_MASK;
  logic        i_clk, i_rst_n, i_fifo_push, i_fifo_pop, i_fifo_clear, i_rx_frame_end;
  logic        i_rx_missing_parity, i_hard_framing_error_irq, i_coll_event;
  logic        i_coll_in_anticoll, i_collision_in_parity;
  logic [6:0]  ev;
  logic [7:0]  i_rx_shift;
  logic [2:0]  i_rx_last_bits, i_coll_bits;
  logic [3:0]  i_coll_bytes;
  logic [31:0] seed = 32'h0000_851C;
  wire logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  wire logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire logic        o_rx_last_byte_valid, o_irq;
  wire logic [7:0]  i_awaddr, i_araddr, o_rx_last_byte;
  wire logic [31:0] i_wdata, o_rdata;
  wire logic [3:0]  i_wstrb;
  wire logic [1:0]  o_bresp, o_rresp;
  wire logic        i_field_wait_timer_irq, i_slot_supply_low_irq, i_p2p_field_on_irq;
  wire logic        i_auto_reply_sent_irq, i_nfcf_target_active_irq;
  wire logic        i_nfca_target_active_star_irq, i_nfca_target_active_irq;
  int n_errors = 0;
  int num_checks = 0;
  int m_pt, m_cnt, m_unf, m_ovr, m_lb, m_np, m_co, m_bs, m_mk;
  assign {i_field_wait_timer_irq, i_slot_supply_low_irq, i_p2p_field_on_irq,
          i_auto_reply_sent_irq, i_nfcf_target_active_irq, i_nfca_target_active_star_irq,
          i_nfca_target_active_irq} = ev;
  rsi_regs u_rsi_regs (
    .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_field_wait_timer_irq, .i_slot_supply_low_irq,
    .i_p2p_field_on_irq, .i_auto_reply_sent_irq, .i_nfcf_target_active_irq,
    .i_nfca_target_active_star_irq, .i_nfca_target_active_irq, .i_fifo_push, .i_fifo_pop,
    .i_fifo_clear, .i_rx_frame_end, .i_rx_last_bits, .i_rx_shift, .i_rx_missing_parity,
    .i_hard_framing_error_irq, .i_coll_event, .i_coll_in_anticoll, .i_coll_bytes,
    .i_coll_bits, .i_collision_in_parity, .o_rx_last_byte, .o_rx_last_byte_valid, .o_irq
  );
  rsi_host_model u_rsi_host_model (
    .i_clk, .o_awvalid(i_awvalid), .i_awready(o_awready), .o_awaddr(i_awaddr),
    .o_wvalid(i_wvalid), .i_wready(o_wready), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
    .i_bvalid(o_bvalid), .o_bready(i_bready), .i_bresp(o_bresp), .o_arvalid(i_arvalid),
    .i_arready(o_arready), .o_araddr(i_araddr), .i_rvalid(o_rvalid), .o_rready(i_rready),
    .i_rdata(o_rdata), .i_rresp(o_rresp)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // reference model, fed by the same inputs the design samples
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      {m_pt, m_cnt, m_unf, m_ovr, m_lb, m_np, m_co, m_bs, m_mk} = '0;
    end else begin
      if (ev != 7'h00) begin
        m_pt = m_pt | int'({ev[6:2], 1'b0, ev[1:0]});
        m_bs = m_bs | 1;
      end
      if (i_fifo_clear) begin
        {m_cnt, m_unf, m_ovr} = '0;
      end else if (i_fifo_push && !i_fifo_pop && m_cnt == 512) begin
        m_ovr = 1;
        m_bs = m_bs | 4;
      end else if (i_fifo_push && !i_fifo_pop) begin
        m_cnt++;
      end else if (i_fifo_pop && !i_fifo_push && m_cnt == 0) begin
        m_unf = 1;
        m_bs = m_bs | 2;
      end else if (i_fifo_pop && !i_fifo_push) begin
        m_cnt--;
      end
      if (i_rx_frame_end) begin
        m_lb = int'(i_rx_last_bits);
        m_np = int'(i_rx_missing_parity && i_rx_last_bits == 3'h0);
      end
      if (i_hard_framing_error_irq) m_bs = m_bs | 16;
      if (i_coll_event && i_coll_in_anticoll) begin
        m_co = int'({i_coll_bytes, i_coll_bits, i_collision_in_parity});
        m_bs = m_bs | 8;
      end
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
  endfunction
  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a)
      A_PT:    return 32'(m_pt);
      A_LO:    return 32'(m_cnt[7:0]);
      A_HI:    return {24'h0, m_cnt[9:8], m_unf[0], m_ovr[0], m_lb[2:0], m_np[0]};
      A_CO:    return 32'(m_co);
      A_ST:    return 32'(m_bs);
      A_MK:    return 32'(m_mk);
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] resp_of(input logic [7:0] a);
    return (a inside {A_PT, A_LO, A_HI, A_CO, A_ST, A_MK}) ? 32'(RSI_RESP_OK)
                                                           : 32'(RSI_RESP_ERR);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdm(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    u_rsi_host_model.rd(a, d, r);
    chk("rdata", d, exp_of(a));
    chk("rresp", 32'(r), resp_of(a));
    if (a == A_PT) m_pt = 0;
  endtask
  task automatic wrm(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_rsi_host_model.wr(a, d, r);
    chk("bresp", 32'(r), resp_of(a));
    if (a == A_ST) m_bs = m_bs & ~int'(d[4:0]);
    if (a == A_MK) m_mk = int'(d[4:0]);
  endtask
  // ends every one-cycle event pulse at the next edge
  task automatic drop;
    @(posedge i_clk);
    {ev, i_fifo_push, i_fifo_pop, i_fifo_clear, i_rx_frame_end} <= '0;
    {i_hard_framing_error_irq, i_coll_event} <= '0;
  endtask
  task automatic burst(input logic pu, input logic po, input int k);
    @(posedge i_clk);
    i_fifo_push <= pu;
    i_fifo_pop  <= po;
    repeat (k - 1) @(posedge i_clk);
    drop();
  endtask
  task automatic irq_chk;
    repeat (2) @(negedge i_clk);
    chk("irq", 32'(o_irq), 32'((m_bs & m_mk) != 0));
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    int i, n;
    logic [7:0] e;
    {ev, i_fifo_push, i_fifo_pop, i_fifo_clear, i_rx_frame_end, i_rx_missing_parity} = '0;
    {i_hard_framing_error_irq, i_coll_event, i_coll_in_anticoll} = '0;
    {i_collision_in_parity, i_rx_shift, i_rx_last_bits, i_coll_bits, i_coll_bytes} = '0;
    i_rst_n = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (i = 0; i < 7; i++) rdm(8'(i * 4) + (i < 6 ? A_PT : 8'h00));
    rdm(A_ST);
    rdm(A_MK);
    wrm(A_LO, 32'h0000_00FF);
    wrm(8'h84, 32'h0000_0001);
    rdm(A_LO);
    for (i = 0; i < 7; i++) begin
      @(posedge i_clk);
      ev <= 7'h01 << i;
      drop();
      rdm(A_PT);
      rdm(A_PT);
    end
    repeat (4) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      ev <= seed[6:0];
      drop();
      rdm(A_PT);
    end
    seed = lfsr(seed);
    n = 3 + int'(seed[5:0]);
    burst(1'b1, 1'b0, n);
    rdm(A_LO);
    burst(1'b1, 1'b1, 1);
    rdm(A_LO);
    burst(1'b0, 1'b1, n + 1);
    rdm(A_HI);
    @(posedge i_clk);
    i_fifo_clear <= 1'b1;
    drop();
    burst(1'b1, 1'b0, 513);
    rdm(A_LO);
    rdm(A_HI);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      i_rx_frame_end <= 1'b1;
      i_rx_last_bits <= 3'(i);
      i_rx_shift <= seed[7:0];
      i_rx_missing_parity <= (i == 0) | seed[8];
      drop();
      @(negedge i_clk);
      e = (i == 0) ? seed[7:0] : seed[7:0] >> (8 - i);
      chk("last_valid", 32'(o_rx_last_byte_valid), 32'h1);
      chk("last_byte", 32'(o_rx_last_byte), 32'(e));
      rdm(A_HI);
    end
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      i_coll_event <= 1'b1;
      i_coll_in_anticoll <= i[0];
      i_coll_bytes <= seed[3:0];
      i_coll_bits <= seed[6:4];
      i_collision_in_parity <= i[1];
      drop();
      rdm(A_CO);
    end
    // last-byte and collision fields are not read back after this
    @(posedge i_clk);
    i_hard_framing_error_irq <= 1'b1;
    drop();
    rdm(A_ST);
    wrm(A_MK, 32'h0000_001F);
    irq_chk();
    wrm(A_MK, 32'h0);
    irq_chk();
    u_rsi_host_model.lag = 3;
    for (i = 0; i < 5; i++) begin
      wrm(A_MK, 32'h1 << i);
      irq_chk();
      wrm(A_ST, 32'h1 << i);
      irq_chk();
      rdm(A_ST);
    end
    wrap_up();
  end
endmodule
